// File: quad_phase_core_pipeline.sv
// quad phase core: fetch/execute pipeline, special registers and data side
`timescale 1ns/10ps
`include "quad_phase_core_consts.svh"
// ****************************************
// Summary of operation
// - input clock divided by four into phases one to four.
// - every instruction cycle runs phases one, two, three, four, repeating.
// - program counter steps in phase one and addresses program memory.
// - fetched word is latched at the boundary into its execution cycle.
// - latched instruction executes over phases one to four during next fetch.
// - operands read in phase two, results written in phase four.
// - counter-changing instructions take two cycles, all others one.
// - every instruction is one 12-bit word on a 12-bit program bus.
// - program and data sit on separate buses, usable in one cycle.
// - 8-bit unit adds, subtracts, shifts and does logic with accumulator.
// - arithmetic is two's complement.
// - two operands: accumulator and file or literal; one operand: either.
// - accumulator is 8 bits and has no data address.
// - carry, digit carry and zero flags updated per instruction.
// - in subtraction carry and digit carry mean no borrow.
// - counter, status and pointer live in the data register space.
// - one status bit selects the program memory page.
// - pointer bits select the data bank above 32 registers.
// - fetching starts at program address zero after reset.
// - flag bits written by a flag-setting instruction keep the logic values.
// ****************************************
module quad_phase_core_pipeline
  import quad_phase_core_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  output logic [11:0] prog_addr,
  input wire logic [11:0] prog_data,
  output logic [6:0] data_addr,
  output logic data_rd_en,
  input wire logic [7:0] data_rdata,
  output logic data_wr_en,
  output logic [7:0] data_wdata,
  output logic [7:0] accumulator_reg,
  output logic [7:0] status_reg,
  output logic [7:0] indirect_pointer_reg,
  output logic [11:0] program_counter,
  output logic [11:0] instruction_latch,
  output phase_type phase_state,
  output logic instr_done,
  output logic flush_cycle
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic decoded_type decode(input logic [11:0] word);
    decoded_type d;
    d = '0;
    d.op = alu_pass_b;
    if (word[11:10] == `CLASS_BYTE) begin
      d.reads_file = 1'b1;
      d.to_file = word[`DEST_BIT];
      d.to_w = ~word[`DEST_BIT];
      case (file_op_type'(word[9:6]))
        fop_store: begin
          d.op = alu_pass_a;
          d.to_w = 1'b0;
          d.reads_file = word[`DEST_BIT];
        end
        fop_clear: begin
          d.op = alu_clear;
          d.upd_z = 1'b1;
        end
        fop_sub: begin
          d.op = subtract_op;
          {d.upd_z, d.upd_c, d.upd_dc} = 3'b111;
        end
        fop_add: begin
          d.op = add_op;
          {d.upd_z, d.upd_c, d.upd_dc} = 3'b111;
        end
        fop_dec: {d.op, d.upd_z} = {alu_dec, 1'b1};
        fop_inc: {d.op, d.upd_z} = {alu_inc, 1'b1};
        fop_or: {d.op, d.upd_z} = {alu_or, 1'b1};
        fop_and: {d.op, d.upd_z} = {alu_and, 1'b1};
        fop_xor: {d.op, d.upd_z} = {alu_xor, 1'b1};
        fop_move: {d.op, d.upd_z} = {alu_pass_b, 1'b1};
        fop_comp: {d.op, d.upd_z} = {alu_comp, 1'b1};
        fop_rrc: {d.op, d.upd_c} = {alu_rrc, 1'b1};
        fop_rlc: {d.op, d.upd_c} = {alu_rlc, 1'b1};
        fop_swap: d.op = alu_swap;
        default: begin
          // unused codes act as nop
          d.reads_file = 1'b0;
          d.to_file = 1'b0;
          d.to_w = 1'b0;
        end
      endcase
    end else if (word[11:9] == `CLASS_BIT) begin
      d.reads_file = 1'b1;
      d.to_file = 1'b1;
      d.is_bit = 1'b1;
      d.bit_set = word[`BITSET_BIT];
    end else if (word[11:9] == `CLASS_JUMP) begin
      d.is_jump = 1'b1;
    end else if (word[11:10] == `CLASS_LIT) begin
      d.use_lit = 1'b1;
      d.to_w = 1'b1;
      unique case (word[9:8])
        2'b00: d.op = alu_pass_b;
        2'b01: {d.op, d.upd_z} = {alu_or, 1'b1};
        2'b10: {d.op, d.upd_z} = {alu_and, 1'b1};
        2'b11: {d.op, d.upd_z} = {alu_xor, 1'b1};
      endcase
    end
    return d;
  endfunction

  // special registers answer inside the core, never on the data bus
  function automatic logic is_internal(input logic [6:0] addr);
    return (addr == `ADDR_INDIRECT) || (addr == `ADDR_PCL) ||
      (addr == `ADDR_STATUS) || (addr == `ADDR_FSR);
  endfunction

  // ****************************************
  // phase generator and arithmetic unit
  // ****************************************
  core_link_if link();
  phase_generator u_phase (
    .clock(clock),
    .rst(rst),
    .link(link.phase_src)
  );
  core_alu u_alu (
    .link(link.alu_unit)
  );

  decoded_type dec;
  logic [4:0] file_sel;
  logic [6:0] eff_addr;
  logic [7:0] operand;
  logic [7:0] next_operand;
  logic [7:0] raw_operand;
  logic [7:0] result;
  logic res_carry;
  logic res_digit;
  logic res_zero;
  logic [7:0] next_status;
  logic [7:0] status_mask;
  logic p1;
  logic p2;
  logic p3;
  logic p4;
  logic file_write;
  logic pcl_write;
  logic flush;

  assign p1 = (link.phase == phase_one);
  assign p2 = (link.phase == phase_two);
  assign p3 = (link.phase == phase_three);
  assign p4 = (link.phase == phase_four);
  assign phase_state = link.phase;
  assign dec = decode(instruction_latch);
  assign link.op = dec.op;
  assign link.acc = accumulator_reg;
  assign link.operand = operand;
  assign link.carry_in = status_reg[`ST_CARRY];
  assign file_write = dec.to_file;
  assign pcl_write = file_write && (eff_addr == `ADDR_PCL);
  assign flush = dec.is_jump || pcl_write;

  // ****************************************
  // data address, banking and indirection
  // ****************************************
  always_comb begin
    file_sel = instruction_latch[`FILE_HI:`FILE_LO];
    if (file_sel == `FILE_INDIRECT) begin
      eff_addr = indirect_pointer_reg[6:0];
    end else if (file_sel <= `SHARED_TOP) begin
      // low half of every bank maps back to bank zero
      eff_addr = {2'b00, file_sel};
    end else begin
      eff_addr = {indirect_pointer_reg[`BANK_HI:`BANK_LO], file_sel};
    end
  end

  // ****************************************
  // operand selection
  // ****************************************
  always_comb begin
    if (dec.use_lit) begin
      raw_operand = instruction_latch[7:0];
    end else if (eff_addr == `ADDR_PCL) begin
      raw_operand = program_counter[7:0];
    end else if (eff_addr == `ADDR_STATUS) begin
      raw_operand = status_reg;
    end else if (eff_addr == `ADDR_FSR) begin
      raw_operand = indirect_pointer_reg;
    end else if (eff_addr == `ADDR_INDIRECT) begin
      // pointer aimed at itself reads as zero
      raw_operand = 8'h00;
    end else begin
      raw_operand = data_rdata;
    end
    next_operand = raw_operand;
    if (dec.is_bit) begin
      if (dec.bit_set) begin
        next_operand = raw_operand |
          8'(8'h01 << instruction_latch[`BITNUM_HI:`BITNUM_LO]);
      end else begin
        next_operand = raw_operand &
          ~8'(8'h01 << instruction_latch[`BITNUM_HI:`BITNUM_LO]);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      operand <= 8'h00;
    end else if (p2) begin
      operand <= next_operand;
    end
  end

  // ****************************************
  // result capture in phase three
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      result <= 8'h00;
      res_carry <= 1'b0;
      res_digit <= 1'b0;
      res_zero <= 1'b0;
    end else if (p3) begin
      result <= link.result;
      res_carry <= link.carry_out;
      res_digit <= link.digit_out;
      res_zero <= link.zero_out;
    end
  end

  // ****************************************
  // program side
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      program_counter <= `PC_RESET;
    end else if (p1) begin
      program_counter <= program_counter + 12'h001;
    end else if (p4 && dec.is_jump) begin
      program_counter <= {2'b00, status_reg[`ST_PAGE], instruction_latch[8:0]};
    end else if (p4 && pcl_write) begin
      program_counter <= {2'b00, status_reg[`ST_PAGE], 1'b0, result};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prog_addr <= `PC_RESET;
    end else if (p1) begin
      prog_addr <= program_counter;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      instruction_latch <= `INSTR_NOP;
      flush_cycle <= 1'b0;
    end else if (p4) begin
      // prefetched word is stale once the counter has moved
      instruction_latch <= flush ? `INSTR_NOP : prog_data;
      flush_cycle <= flush;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= p4 && !flush_cycle;
    end
  end

  // ****************************************
  // data side bus, separate from program bus
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      data_addr <= 7'h00;
      data_rd_en <= 1'b0;
    end else begin
      if (p1) begin
        data_addr <= eff_addr;
      end
      data_rd_en <= p1 && dec.reads_file && !is_internal(eff_addr);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_wr_en <= 1'b0;
      data_wdata <= 8'h00;
    end else begin
      if (p3) begin
        data_wdata <= link.result;
      end
      data_wr_en <= p3 && file_write && !is_internal(eff_addr);
    end
  end

  // ****************************************
  // accumulator, pointer and status
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      accumulator_reg <= `ACC_RESET;
    end else if (p4 && dec.to_w) begin
      accumulator_reg <= result;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      indirect_pointer_reg <= `FSR_RESET;
    end else if (p4 && file_write && (eff_addr == `ADDR_FSR)) begin
      indirect_pointer_reg <= result;
    end
  end

  always_comb begin
    next_status = status_reg;
    status_mask = `STATUS_WRITE_MASK;
    if (dec.upd_z || dec.upd_c || dec.upd_dc) begin
      status_mask = `STATUS_WRITE_MASK & ~`STATUS_FLAG_MASK;
    end
    if (p4 && file_write && (eff_addr == `ADDR_STATUS)) begin
      next_status = (result & status_mask) | (status_reg & ~status_mask);
    end
    if (p4 && dec.upd_z) begin
      next_status[`ST_ZERO] = res_zero;
    end
    if (p4 && dec.upd_c) begin
      next_status[`ST_CARRY] = res_carry;
    end
    if (p4 && dec.upd_dc) begin
      next_status[`ST_DIGIT] = res_digit;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= next_status;
    end
  end
endmodule // quad_phase_core_pipeline

// File: quad_phase_core_consts.svh
// constants of the quad phase core: offsets, field positions, reset values
`ifndef QUAD_PHASE_CORE_CONSTS_SVH
`define QUAD_PHASE_CORE_CONSTS_SVH
// ****************************************
// reset values
// ****************************************
`define PC_RESET 12'h000
`define ACC_RESET 8'h00
`define STATUS_RESET 8'h18
`define FSR_RESET 8'h00
`define INSTR_NOP 12'h000
// ****************************************
// data space addresses
// ****************************************
`define FILE_INDIRECT 5'h00
`define SHARED_TOP 5'h0f
`define ADDR_INDIRECT 7'h00
`define ADDR_PCL 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_FSR 7'h04
// ****************************************
// status and pointer fields
// ****************************************
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2
`define ST_PAGE 5
`define STATUS_WRITE_MASK 8'ha7
`define STATUS_FLAG_MASK 8'h07
`define BANK_HI 6
`define BANK_LO 5
// ****************************************
// instruction fields
// ****************************************
`define CLASS_BYTE 2'b00
`define CLASS_BIT 3'b010
`define CLASS_JUMP 3'b101
`define CLASS_LIT 2'b11
`define FILE_HI 4
`define FILE_LO 0
`define DEST_BIT 5
`define BITSET_BIT 8
`define BITNUM_HI 7
`define BITNUM_LO 5
`endif

// File: quad_phase_core_pkg.sv
// types of the quad phase core
package quad_phase_core_pkg;
  typedef enum logic [3:0] {
    phase_one = 4'b0001,
    phase_two = 4'b0010,
    phase_three = 4'b0100,
    phase_four = 4'b1000
  } phase_type;
  typedef enum logic [3:0] {
    alu_pass_b = 4'h0, alu_pass_a = 4'h1, alu_clear = 4'h2, add_op = 4'h3,
    subtract_op = 4'h4, alu_dec = 4'h5, alu_inc = 4'h6, alu_or = 4'h7,
    alu_and = 4'h8, alu_xor = 4'h9, alu_comp = 4'ha, alu_rrc = 4'hb,
    alu_rlc = 4'hc, alu_swap = 4'hd
  } alu_op_type;
  typedef enum logic [3:0] {
    fop_store = 4'h0, fop_clear = 4'h1, fop_sub = 4'h2, fop_dec = 4'h3,
    fop_or = 4'h4, fop_and = 4'h5, fop_xor = 4'h6, fop_add = 4'h7,
    fop_move = 4'h8, fop_comp = 4'h9, fop_inc = 4'ha, fop_rrc = 4'hc,
    fop_rlc = 4'hd, fop_swap = 4'he
  } file_op_type;
  typedef struct packed {
    alu_op_type op;
    logic reads_file;
    logic to_file;
    logic to_w;
    logic use_lit;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic is_jump;
    logic is_bit;
    logic bit_set;
  } decoded_type;
endpackage

// File: core_link_if.sv
// phase and arithmetic signals shared inside the core
`timescale 1ns/10ps
interface core_link_if;
  import quad_phase_core_pkg::*;
  phase_type phase;
  alu_op_type op;
  logic [7:0] acc;
  logic [7:0] operand;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic digit_out;
  logic zero_out;
  modport phase_src (output phase);
  modport alu_unit (input op, acc, operand, carry_in,
    output result, carry_out, digit_out, zero_out);
  modport core (input phase, result, carry_out, digit_out, zero_out,
    output op, acc, operand, carry_in);
endinterface

// File: phase_generator.sv
// four phase divider of the input clock
`timescale 1ns/10ps
module phase_generator
  import quad_phase_core_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  core_link_if.phase_src link
);
  always_ff @(posedge clock) begin
    if (rst) begin
      link.phase <= phase_one;
    end else begin
      unique case (link.phase)
        phase_one: link.phase <= phase_two;
        phase_two: link.phase <= phase_three;
        phase_three: link.phase <= phase_four;
        phase_four: link.phase <= phase_one;
      endcase
    end
  end
endmodule // phase_generator

// File: core_alu.sv
// 8-bit arithmetic and logic unit of the core
`timescale 1ns/10ps
module core_alu
  import quad_phase_core_pkg::*;
(
  core_link_if.alu_unit link
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  // subtraction is b plus not a plus one, so carry out means no borrow
  always_comb begin
    sum = 9'h000;
    low_sum = 5'h00;
    link.result = 8'h00;
    link.carry_out = link.carry_in;
    link.digit_out = 1'b0;
    unique case (link.op)
      alu_pass_b: link.result = link.operand;
      alu_pass_a: link.result = link.acc;
      alu_clear: link.result = 8'h00;
      add_op: begin
        sum = {1'b0, link.operand} + {1'b0, link.acc};
        low_sum = {1'b0, link.operand[3:0]} + {1'b0, link.acc[3:0]};
        link.result = sum[7:0];
        link.carry_out = sum[8];
        link.digit_out = low_sum[4];
      end
      subtract_op: begin
        sum = {1'b0, link.operand} + {1'b0, ~link.acc} + 9'h001;
        low_sum = {1'b0, link.operand[3:0]} + {1'b0, ~link.acc[3:0]} + 5'h01;
        link.result = sum[7:0];
        link.carry_out = sum[8];
        link.digit_out = low_sum[4];
      end
      alu_dec: link.result = link.operand - 8'h01;
      alu_inc: link.result = link.operand + 8'h01;
      alu_or: link.result = link.operand | link.acc;
      alu_and: link.result = link.operand & link.acc;
      alu_xor: link.result = link.operand ^ link.acc;
      alu_comp: link.result = ~link.operand;
      alu_rrc: begin
        link.result = {link.carry_in, link.operand[7:1]};
        link.carry_out = link.operand[0];
      end
      alu_rlc: begin
        link.result = {link.operand[6:0], link.carry_in};
        link.carry_out = link.operand[7];
      end
      alu_swap: link.result = {link.operand[3:0], link.operand[7:4]};
    endcase
    link.zero_out = (link.result == 8'h00);
  end
endmodule // core_alu

// File: quad_phase_core_pipeline_assertions.sv
// concurrent checks on the ports of the quad phase core
`timescale 1ns/10ps
module quad_phase_core_assertions
  import quad_phase_core_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] prog_addr,
  input wire logic [11:0] prog_data,
  input wire logic data_rd_en,
  input wire logic data_wr_en,
  input wire logic [11:0] program_counter,
  input wire logic [11:0] instruction_latch,
  input wire phase_type phase_state,
  input wire logic instr_done,
  input wire logic flush_cycle
);
  // reset is released on a clock edge, so checks stay off one edge longer
  logic prev_rst;
  always_ff @(posedge clock) begin
    prev_rst <= rst;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || prev_rst);
  // ****
  // phases and pipeline
  // ****
  a_phase_one_next: assert property (
    phase_state == phase_one |=> phase_state == phase_two)
    else $error("phase two does not follow phase one");
  a_cycle_of_four: assert property (
    phase_state == phase_one |-> ##4 phase_state == phase_one)
    else $error("instruction cycle is not four clocks");
  a_reset_start: assert property (
    $fell(rst) |-> phase_state == phase_one && instruction_latch == 12'h000
      && program_counter == 12'h000)
    else $error("core does not restart empty at phase one");
  a_pc_step_fetch: assert property (
    phase_state == phase_one && !flush_cycle |=> prog_addr == $past(program_counter)
      && program_counter == $past(program_counter) + 12'h001)
    else $error("counter did not step in phase one");
  a_fetch_addr_held: assert property (
    phase_state != phase_one |=> $stable(prog_addr))
    else $error("program address moved outside phase one");
  a_latch_capture: assert property (
    phase_state == phase_four |=> instruction_latch == $past(prog_data) || flush_cycle)
    else $error("fetched word not latched at cycle boundary");
  a_latch_held: assert property (
    phase_state != phase_four |=> $stable(instruction_latch))
    else $error("instruction latch changed mid cycle");
  a_read_phase_two: assert property (
    data_rd_en |-> phase_state == phase_two)
    else $error("operand read outside phase two");
  a_write_phase_four: assert property (
    data_wr_en |-> phase_state == phase_four)
    else $error("result write outside phase four");
  a_jump_flushes: assert property (
    phase_state == phase_four && instruction_latch[11:9] == 3'b101 && !flush_cycle
      |=> flush_cycle && instruction_latch == 12'h000)
    else $error("jump did not discard the prefetched word");
  a_flush_one_cycle: assert property (
    $rose(flush_cycle) |-> flush_cycle[*4] ##1 !flush_cycle)
    else $error("branch penalty is not one instruction cycle");
  a_flush_quiet: assert property (
    flush_cycle |-> !data_rd_en && !data_wr_en)
    else $error("inserted nop touched the data bus");
  a_done_pulse: assert property (
    instr_done |-> phase_state == phase_one ##1 !instr_done)
    else $error("completion pulse misplaced");
  c_flush: cover property (flush_cycle);
  c_read: cover property (data_rd_en);
  c_write: cover property (data_wr_en);
  c_page_jump: cover property (program_counter[9]);
endmodule // quad_phase_core_assertions

bind quad_phase_core_pipeline quad_phase_core_assertions i_quad_phase_core_assertions (
  .clock(clock), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
  .data_rd_en(data_rd_en), .data_wr_en(data_wr_en), .program_counter(program_counter),
  .instruction_latch(instruction_latch), .phase_state(phase_state),
  .instr_done(instr_done), .flush_cycle(flush_cycle));

// File: core_memory_model.sv
// program memory and register file facing the core
`timescale 1ns/10ps
module core_memory_model (
  input wire logic clock,
  input wire logic [11:0] prog_addr,
  output logic [11:0] prog_data,
  input wire logic [6:0] data_addr,
  input wire logic data_rd_en,
  output logic [7:0] data_rdata,
  input wire logic data_wr_en,
  input wire logic [7:0] data_wdata
);
  // ****
  // storage, program image loaded by the bench
  // ****
  logic [11:0] rom [0:4095];
  logic [7:0] ram [0:127];
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 128; i++) ram[i] = 8'h00;
  end
  assign prog_data = rom[prog_addr];
  // released bus shows the inverse of the last byte, never a stale copy
  assign data_rdata = data_rd_en ? ram[data_addr] : ~last;
  always @(posedge clock) begin
    if (data_rd_en) last <= ram[data_addr];
    if (data_wr_en) ram[data_addr] <= data_wdata;
  end
endmodule // core_memory_model

// File: tb_quad_phase_core_pipeline.sv
// self-checking bench of the quad phase core
`timescale 1ns/10ps
module tb_quad_phase_core_pipeline;
  import quad_phase_core_pkg::*;
  typedef struct packed {
    logic chk;
    logic [2:0] flags;
    logic [6:0] addr;
    logic [7:0] data;
  } note_type;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [11:0] prog_addr, prog_data, program_counter, instruction_latch;
  logic [6:0] data_addr;
  logic data_rd_en, data_wr_en, instr_done, flush_cycle;
  logic [7:0] data_rdata, data_wdata, accumulator_reg, status_reg, indirect_pointer_reg;
  phase_type phase_state;
  note_type notes[$];
  note_type cur;
  logic pend = 1'b0;
  logic [2:0] pflags = 3'b000;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  integer seed = 32'hc55a;
  logic [7:0] rnd;
  logic [11:0] prog [0:19];
  always #2 clock = ~clock;
  quad_phase_core_pipeline i_quad_phase_core_pipeline (
    .clock(clock), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rd_en(data_rd_en), .data_rdata(data_rdata),
    .data_wr_en(data_wr_en), .data_wdata(data_wdata), .accumulator_reg(accumulator_reg),
    .status_reg(status_reg), .indirect_pointer_reg(indirect_pointer_reg),
    .program_counter(program_counter), .instruction_latch(instruction_latch),
    .phase_state(phase_state), .instr_done(instr_done), .flush_cycle(flush_cycle));
  core_memory_model i_core_memory_model (
    .clock(clock), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rd_en(data_rd_en), .data_rdata(data_rdata), .data_wr_en(data_wr_en),
    .data_wdata(data_wdata));
  // ****
  // comparison and closing
  // ****
  task automatic compare_byte(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      fail_count++;
      $display("BAD %0t byte %h expected %h", $time, got, want);
    end
  endtask
  task automatic compare_flags(input logic [2:0] got, input logic [2:0] want);
    num_checks++;
    if (got !== want) begin
      fail_count++;
      $display("BAD %0t flags %b expected %b", $time, got, want);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****
  // result watcher: each write takes the oldest note
  // ****
  always @(posedge clock) begin
    if (!rst && data_wr_en === 1'b1) begin
      if (notes.size() == 0) begin
        fail_count++;
        $display("BAD %0t write with nothing expected", $time);
      end else begin
        cur = notes.pop_front();
        compare_byte({1'b0, data_addr}, {1'b0, cur.addr});
        compare_byte(data_wdata, cur.data);
        pend <= cur.chk;
        pflags <= cur.flags;
      end
    end
    if (pend) begin
      compare_flags(status_reg[2:0], pflags);
      pend <= 1'b0;
    end
  end
  // hang guard, the program needs about 100 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 600) begin
      fail_count++;
      $display("BAD %0t run did not finish", $time);
      finish_test();
    end
  end
  // ****
  // stimulus
  // ****
  initial begin
    rnd = 8'($random(seed));
    // sub, clear of status, add, jump over two words, indirect and banked stores,
    // page bit set, then a jump into the upper page that spins there
    prog = '{12'hc0f, 12'h030, 12'hc01, 12'h090, 12'h063, 12'h032, 12'h1f0, 12'ha0a,
      12'hcff, 12'hcff, 12'hf0e, 12'h031, 12'hc20, 12'h024, 12'h020, 12'h030,
      12'hc00, 12'h033, 12'h5a3, 12'ha12};
    prog[16] = {4'hc, rnd};
    for (int i = 0; i < 4096; i++) i_core_memory_model.rom[i] = 12'h000;
    for (int i = 0; i < 20; i++) i_core_memory_model.rom[i] = prog[i];
    i_core_memory_model.rom[12'h212] = 12'ha12;
    notes.push_back('{1'b1, 3'b000, 7'h10, 8'h0f});
    notes.push_back('{1'b1, 3'b111, 7'h12, 8'h0e});
    notes.push_back('{1'b1, 3'b010, 7'h10, 8'h1d});
    notes.push_back('{1'b1, 3'b110, 7'h11, 8'h00});
    notes.push_back('{1'b0, 3'b000, 7'h20, 8'h20});
    notes.push_back('{1'b0, 3'b000, 7'h30, 8'h20});
    notes.push_back('{1'b0, 3'b000, 7'h33, rnd});
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    #1;
    compare_byte(status_reg, 8'h18);
    for (int k = 0; k < 300 && notes.size() != 0; k++) @(posedge clock);
    if (notes.size() != 0) begin
      fail_count++;
      $display("BAD %0t expected writes never came", $time);
    end
    repeat (12) @(posedge clock);
    #1;
    compare_byte(accumulator_reg, rnd);
    compare_byte(indirect_pointer_reg, 8'h20);
    compare_byte(program_counter[11:4], 8'h21);
    $display("program test done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    compare_byte(instruction_latch[7:0], 8'h00);
    compare_byte(program_counter[7:0], 8'h00);
    compare_byte(status_reg, 8'h18);
    compare_byte(accumulator_reg, 8'h00);
    @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    $display("reset test done");
    finish_test();
  end
endmodule // tb_quad_phase_core_pipeline
